// [inc/ebca_pkg.sv]
// Package: register map, field layout and carrier types of the external bus control block
package ebca_pkg;

    // ****************************************************************
    // Register offsets (32-bit access address; 16-bit access adds two)
    // ****************************************************************
    localparam logic [31:0] EBCA_OFF_BUS_CONTROL_ONE = 32'hFFFFFFE0;
    localparam logic [31:0] EBCA_OFF_BUS_CONTROL_TWO = 32'hFFFFFFE4;
    localparam logic [31:0] EBCA_OFF_WAIT_CONTROL = 32'h0FFFFFE8;
    localparam logic [31:0] EBCA_OFF_MEMORY_TYPE_CONTROL = 32'hFFFFFFEC;
    localparam logic [31:0] EBCA_OFF_REFRESH_TIMER_CONTROL_STATUS = 32'hFFFFFF60;
    localparam logic [31:0] EBCA_OFF_REFRESH_TIMER_COUNT = 32'hFFFFFFF4;
    localparam logic [31:0] EBCA_OFF_REFRESH_TIME_CONSTANT = 32'h0FFFFFF8;
    localparam logic [31:0] EBCA_OFF_LINK_CONTROL = 32'hFFFFFFF0;
    localparam logic [31:0] EBCA_HALF_OFFSET = 32'h00000002;

    // ****************************************************************
    // Register indices and reset values
    // ****************************************************************
    localparam int EBCA_NUM_REGS = 8;
    localparam logic [3:0] EBCA_IDX_BCR_ONE = 4'h0;
    localparam logic [3:0] EBCA_IDX_LINK = 4'h7;
    localparam logic [3:0] EBCA_IDX_NONE = 4'hF;
    localparam logic [7:0][31:0] EBCA_REG_OFFSET = {
        EBCA_OFF_LINK_CONTROL, EBCA_OFF_REFRESH_TIME_CONSTANT, EBCA_OFF_REFRESH_TIMER_COUNT,
        EBCA_OFF_REFRESH_TIMER_CONTROL_STATUS, EBCA_OFF_MEMORY_TYPE_CONTROL, EBCA_OFF_WAIT_CONTROL,
        EBCA_OFF_BUS_CONTROL_TWO, EBCA_OFF_BUS_CONTROL_ONE};
    localparam logic [7:0][15:0] EBCA_REG_RESET = {
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hAAFF, 16'h00FC, 16'h03F0};
    // Bits software may change; other bits keep reset zero, but the master and released bits read back status
    localparam logic [7:0][15:0] EBCA_REG_WMASK = {
        16'h0001, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h1FF7};

    // ****************************************************************
    // Write key and field positions
    // ****************************************************************
    localparam logic [15:0] EBCA_WRITE_KEY = 16'hA55A;
    localparam int EBCA_BIT_MASTER = 15;
    localparam int EBCA_BIT_PARTIAL_SHARE = 10;
    localparam int EBCA_MEMKIND_LSB = 0;
    localparam int EBCA_BIT_SELF_REFRESH = 0;
    localparam int EBCA_BIT_RELEASED = 1;
    localparam int EBCA_SPACE_LSB = 25;
    localparam int EBCA_EXT_ADDR_W = 27;
    localparam logic [1:0] EBCA_SPACE_SHARED = 2'h2;
    localparam logic [1:0] EBCA_SPACE_DRAM = 2'h3;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        EBCA_MEM_BASIC = 2'b00,
        EBCA_MEM_SDRAM = 2'b01,
        EBCA_MEM_DRAM = 2'b10,
        EBCA_MEM_PSRAM = 2'b11
    } ebca_mem_e;

    typedef enum logic [1:0] {
        EBCA_ARB_TOTAL = 2'b00,
        EBCA_ARB_PARTIAL = 2'b01,
        EBCA_ARB_SLAVE = 2'b10
    } ebca_arb_e;

    // Access request from the CPU side
    typedef struct packed {
        logic valid;
        logic write;
        logic vector;
        logic [1:0] lane_en;
        logic [31:0] addr;
    } ebca_req_s;

    // External pin group, all low-active except the clock enable, vector flag and address
    typedef struct packed {
        logic [3:0] select_n;
        logic lane_two_strobe_n;
        logic lane_low_strobe_n;
        logic read_n;
        logic drive_oe_n;
        logic arb_out_n;
        logic sdram_clock_enable;
        logic vector_fetch_indicator;
        logic [EBCA_EXT_ADDR_W-1:0] addr;
    } ebca_pins_s;

endpackage

// [logic/ebca_top.sv]
// Design: external bus control register bank, chip-select decode, lane strobes and arbitration pins
// Notes on behaviour
// - lane-two strobe: column strobe, SDRAM mask, write strobe or write flag by memory kind
// - low-lane strobe: column strobe, SDRAM mask, write strobe or write flag by memory kind
// - shared input is bus permission in partial/slave, release request in total master
// - shared output is bus request in partial/slave, bus grant in total master
// - SDRAM clock enable stays driven when released; drops for self-refresh
// - registers are 16 bits; 32-bit reads return zero upper half
// - 32-bit write updates register only when upper data half equals key
// - 16-bit accesses read only; 16-bit writes ignored
// - 16-bit access address is the 32-bit address plus two
// - address map split into four spaces; space three takes any device kind from the memory kind field, space two only SDRAM
// - cache-through region aliases the cached region; 128 MB reachable
// - two top address bits choose one of four selects, 32 MB each
//
// Added by the designer: strobed register access.
module ebca_top (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Register port
    input wire logic [31:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wide_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // CPU access request
    input ebca_pkg::ebca_req_s req_i,
    output logic req_ack_o,
    // Mode strap and shared arbitration input (low active)
    input wire logic slave_mode_i,
    input wire logic arb_in_n_i,
    // External pins
    output ebca_pkg::ebca_pins_s pins_o
);
    import ebca_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [EBCA_NUM_REGS-1:0][15:0] regs;
        logic [31:0] rdata;
        logic slave;
        logic released;
        logic ack;
        ebca_pins_s pins;
    } ebca_state_s;

    ebca_state_s state;
    ebca_state_s next_state;

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Register index from address and access width
    function automatic logic [3:0] reg_index(input logic [31:0] addr, input logic wide);
        logic [31:0] base;
        logic [3:0] idx;
        base = wide ? addr : addr - EBCA_HALF_OFFSET;
        idx = EBCA_IDX_NONE;
        for (int i = 0; i < EBCA_NUM_REGS; i++) begin
            if (base == EBCA_REG_OFFSET[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // Memory kind of a space; only spaces two and three take special memories
    function automatic ebca_mem_e space_kind(input logic [1:0] space, input logic [2:0] kind_field);
        ebca_mem_e kind;
        kind = EBCA_MEM_BASIC;
        if (space == EBCA_SPACE_DRAM) begin
            kind = ebca_mem_e'(kind_field[1:0]);
        end else if (space == EBCA_SPACE_SHARED && kind_field[1:0] == EBCA_MEM_SDRAM) begin
            kind = EBCA_MEM_SDRAM;
        end
        return kind;
    endfunction

    // Low-active lane strobe for one byte lane
    function automatic logic lane_strobe_n(input ebca_mem_e kind, input logic go, input logic wr,
                                           input logic en);
        logic active;
        unique case (kind)
            // Column strobe and SDRAM mask open the lane for reads and writes
            EBCA_MEM_DRAM, EBCA_MEM_SDRAM: active = go & en;
            // Write strobe and write flag only mark writes
            EBCA_MEM_PSRAM, EBCA_MEM_BASIC: active = go & wr & en;
        endcase
        return ~active;
    endfunction

    // ****************************************************************
    // Decode signals
    // ****************************************************************
    logic [3:0] wr_idx;
    logic [3:0] rd_idx;
    logic [1:0] space;
    logic external;
    ebca_arb_e arb_mode;
    ebca_mem_e kind;
    logic shared_need;
    logic permitted;
    logic go;

    // Register address decode for both strobes
    assign wr_idx = reg_index(reg_addr_i, reg_wide_i);
    assign rd_idx = reg_index(reg_addr_i, reg_wide_i);

    // Cache-through bit 29 ignored so both views hit the same memory
    assign external = (req_i.addr[31:30] == 2'b00) && (req_i.addr[28:27] == 2'b00);
    assign space = req_i.addr[EBCA_SPACE_LSB+1:EBCA_SPACE_LSB];
    assign kind = space_kind(space, state.regs[EBCA_IDX_BCR_ONE][EBCA_MEMKIND_LSB+2:EBCA_MEMKIND_LSB]);

    // Arbitration mode from strap and partial-share bit
    always_comb begin
        if (state.slave) begin
            arb_mode = EBCA_ARB_SLAVE;
        end else if (state.regs[EBCA_IDX_BCR_ONE][EBCA_BIT_PARTIAL_SHARE]) begin
            arb_mode = EBCA_ARB_PARTIAL;
        end else begin
            arb_mode = EBCA_ARB_TOTAL;
        end
    end

    // Shared input meaning depends on mode
    always_comb begin
        shared_need = 1'b0;
        permitted = 1'b1;
        unique case (arb_mode)
            EBCA_ARB_SLAVE: begin
                shared_need = req_i.valid & external;
                permitted = ~arb_in_n_i;
            end
            EBCA_ARB_PARTIAL: begin
                // Only the shared space waits for permission
                shared_need = req_i.valid & external & (space == EBCA_SPACE_SHARED);
                permitted = ~arb_in_n_i | ~shared_need;
            end
            EBCA_ARB_TOTAL: begin
                // Release request wins over an access requested in the same cycle
                permitted = arb_in_n_i;
            end
            default: begin
                shared_need = 1'b0;
                permitted = 1'b0;
            end
        endcase
    end

    assign go = req_i.valid & external & permitted;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [15:0] merged;
        logic [15:0] view;
        merged = 16'h0000;
        view = 16'h0000;
        next_state = state;
        next_state.slave = slave_mode_i;

        // Keyed 32-bit writes only; others vanish without any error
        if (reg_wr_i && reg_wide_i && wr_idx != EBCA_IDX_NONE
            && reg_wdata_i[31:16] == EBCA_WRITE_KEY) begin
            merged = (state.regs[wr_idx[2:0]] & ~EBCA_REG_WMASK[wr_idx[2:0]])
                     | (reg_wdata_i[15:0] & EBCA_REG_WMASK[wr_idx[2:0]]);
            next_state.regs[wr_idx[2:0]] = merged;
        end

        // Read data valid in the cycle after the strobe only
        next_state.rdata = 32'h00000000;
        if (reg_rd_i && rd_idx != EBCA_IDX_NONE) begin
            view = state.regs[rd_idx[2:0]];
            if (rd_idx == EBCA_IDX_BCR_ONE) begin
                view[EBCA_BIT_MASTER] = state.slave;
            end else if (rd_idx == EBCA_IDX_LINK) begin
                view[EBCA_BIT_RELEASED] = state.released;
            end
            next_state.rdata = {16'h0000, view};
        end

        // Bus released: total master granted away, or no permission in slave mode
        next_state.released = (arb_mode == EBCA_ARB_TOTAL) ? ~arb_in_n_i
                            : (arb_mode == EBCA_ARB_SLAVE) ? arb_in_n_i : 1'b0;

        // Pins registered one cycle after the accepted request
        next_state.ack = go;
        next_state.pins.select_n = 4'hF;
        if (go) begin
            next_state.pins.select_n[space] = 1'b0;
        end
        next_state.pins.lane_two_strobe_n = lane_strobe_n(kind, go, req_i.write, req_i.lane_en[1]);
        next_state.pins.lane_low_strobe_n = lane_strobe_n(kind, go, req_i.write, req_i.lane_en[0]);
        next_state.pins.read_n = ~(go & ~req_i.write);
        next_state.pins.drive_oe_n = next_state.released;
        next_state.pins.vector_fetch_indicator = go & req_i.vector;
        next_state.pins.addr = go ? req_i.addr[EBCA_EXT_ADDR_W-1:0] : state.pins.addr;

        // Shared output always driven, even when released
        if (arb_mode == EBCA_ARB_TOTAL) begin
            next_state.pins.arb_out_n = arb_in_n_i;
        end else begin
            next_state.pins.arb_out_n = ~shared_need;
        end

        // Clock enable never floats; self-refresh bit drops it
        next_state.pins.sdram_clock_enable =
            ~state.regs[EBCA_IDX_LINK][EBCA_BIT_SELF_REFRESH];
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state.regs <= EBCA_REG_RESET;
            state.rdata <= 32'h00000000;
            state.slave <= 1'b0;
            state.released <= 1'b0;
            state.ack <= 1'b0;
            state.pins.select_n <= 4'hF;
            state.pins.lane_two_strobe_n <= 1'b1;
            state.pins.lane_low_strobe_n <= 1'b1;
            state.pins.read_n <= 1'b1;
            state.pins.drive_oe_n <= 1'b0;
            state.pins.arb_out_n <= 1'b1;
            state.pins.sdram_clock_enable <= 1'b1;
            state.pins.vector_fetch_indicator <= 1'b0;
            state.pins.addr <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from flops
    assign reg_rdata_o = state.rdata;
    assign req_ack_o = state.ack;
    assign pins_o = state.pins;

endmodule

// [tb/ebca_top_sva.sv]
// Checker: port-level properties of the external bus control block
module ebca_top_sva
    import ebca_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input ebca_pkg::ebca_req_s req_i,
    input wire logic req_ack_o,
    input wire logic slave_mode_i,
    input wire logic arb_in_n_i,
    input ebca_pkg::ebca_pins_s pins_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // Register port: 16-bit contents, data only in the cycle after a read
    a_upper_half_zero: assert property (reg_rdata_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_read_data_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h00000000)
        else $error("read data outside its cycle");
    // Accesses: only external addresses, decoded from the two top bits
    a_ack_has_cause: assert property (req_ack_o |->
        $past(req_i.valid) && $past(req_i.addr[31:30]) == 2'h0 && $past(req_i.addr[28:27]) == 2'h0)
        else $error("ack without external request");
    a_select_decode: assert property (
        pins_o.select_n == (req_ack_o ? ~(4'h1 << $past(req_i.addr[26:25])) : 4'hF))
        else $error("wrong chip select");
    a_alias_address: assert property (req_ack_o |-> pins_o.addr == $past(req_i.addr[26:0]))
        else $error("external address not aliased");
    a_read_pulse: assert property (pins_o.read_n == !(req_ack_o && !$past(req_i.write)))
        else $error("read pulse mismatch");
    // Lane strobes stay off without an access or with the lane disabled
    a_lanes_idle: assert property (
        !req_ack_o |-> pins_o.lane_two_strobe_n && pins_o.lane_low_strobe_n)
        else $error("lane strobe without access");
    a_lane_two_off: assert property (req_ack_o && !$past(req_i.lane_en[1]) |-> pins_o.lane_two_strobe_n)
        else $error("lane two strobe on disabled lane");
    a_lane_low_off: assert property (req_ack_o && !$past(req_i.lane_en[0]) |-> pins_o.lane_low_strobe_n)
        else $error("low lane strobe on disabled lane");
    // Slave accesses wait for permission on the shared input
    a_slave_needs_grant: assert property (
        slave_mode_i && $past(slave_mode_i) && arb_in_n_i && req_i.valid |=> !req_ack_o)
        else $error("slave access without permission");
endmodule

bind ebca_top ebca_top_sva u_sva (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .req_i(req_i), .req_ack_o(req_ack_o), .slave_mode_i(slave_mode_i),
    .arb_in_n_i(arb_in_n_i), .pins_o(pins_o));

// [tb/ebca_ext_model.sv]
// Partner model: other bus master on the arbitration pins and an external data buffer
module ebca_ext_model
    import ebca_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input ebca_pkg::ebca_pins_s pins_i,
    input wire logic total_i,
    input wire logic release_i,
    input wire logic [3:0] lag_i,
    output logic arb_n_o,
    output logic [15:0] rd_data_o
);
    logic [3:0] held;
    logic [15:0] last;
    // Grant after lag cycles of request, or ask for the bus in total master mode
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            held <= 4'h0;
            arb_n_o <= 1'b1;
            last <= 16'h0000;
        end else begin
            held <= pins_i.arb_out_n ? 4'h0 : held + {3'h0, held != 4'hF};
            arb_n_o <= total_i ? !release_i : !(!pins_i.arb_out_n && held >= lag_i);
            last <= pins_i.read_n ? last : pins_i.addr[15:0];
        end
    end
    // Buffer drives data only in the read pulse; otherwise the inverted last read address
    assign rd_data_o = pins_i.read_n ? ~last : pins_i.addr[15:0];
endmodule

// [tb/external_bus_control_access_tb.sv]
// Testbench: registers, access decode, lane strobes and arbitration of the external bus block
module external_bus_control_access_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ebca_pkg::*;
    typedef struct packed {logic wr; logic wide; logic [31:0] a; logic [31:0] d;} ebca_row_s;
    logic ref_clk_i = 1'b0, rstn_i = 1'b0, reg_wide_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [31:0] reg_addr_i = 32'h0, reg_wdata_i = 32'h0, reg_rdata_o;
    logic slave_mode_i = 1'b0, total = 1'b1, rel = 1'b0, req_ack_o, arb_in_n_i;
    logic [1:0] kind = 2'h0;
    logic [15:0] rd_data;
    ebca_req_s req_i = '0;
    ebca_pins_s pins_o;
    int n_mismatch = 0, comparisons = 0;
    // Reads, writes, wrong key, narrow write and unmapped places
    ebca_row_s rows [15] = '{'{0, 1, 32'hFFFFFFE0, 32'h03F0}, '{0, 0, 32'hFFFFFFE6, 32'h00FC},
        '{0, 1, 32'h0FFFFFE8, 32'hAAFF}, '{0, 0, 32'hFFFFFFEE, 32'h0}, '{0, 1, 32'hFFFFFF60, 32'h0},
        '{0, 0, 32'hFFFFFFF6, 32'h0}, '{0, 1, 32'h0FFFFFF8, 32'h0}, '{1, 1, 32'hFFFFFFE4, 32'hA55A1234},
        '{0, 1, 32'hFFFFFFE4, 32'h1234}, '{1, 1, 32'hFFFFFFE4, 32'h5AA51111}, '{0, 0, 32'hFFFFFFE6, 32'h1234},
        '{1, 0, 32'hFFFFFFE6, 32'hA55A2222}, '{0, 1, 32'hFFFFFFE4, 32'h1234}, '{0, 0, 32'hFFFFFFE4, 32'h0},
        '{0, 1, 32'hFFFFFF00, 32'h0}};

    always #25 ref_clk_i = ~ref_clk_i;

    ebca_top uut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wide_i(reg_wide_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .req_i(req_i), .req_ack_o(req_ack_o), .slave_mode_i(slave_mode_i), .arb_in_n_i(arb_in_n_i), .pins_o(pins_o));
    ebca_ext_model u_ext (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pins_i(pins_o), .total_i(total),
        .release_i(rel), .lag_i(4'h3), .arb_n_o(arb_in_n_i), .rd_data_o(rd_data));

    // ****************************************************************
    // Bus tasks and checking
    // ****************************************************************
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic wide, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wide_i <= wide;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic wide, input logic [31:0] exp);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wide_i <= wide;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 cmp("reg_rdata_o", exp, reg_rdata_o);
    endtask
    // Holds the request until the permission level is seen, so it is taken exactly once
    task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] ln, input logic v,
        input logic perm, input logic exp);
        int n;
        logic dyn;
        logic [3:0] sel;
        n = 0;
        dyn = (a[26:25] == 2'h3 && (kind == 2'h1 || kind == 2'h2)) || (a[26:25] == 2'h2 && kind == 2'h1);
        sel = exp ? ~(4'h1 << a[26:25]) : 4'hF;
        @(posedge ref_clk_i);
        req_i <= '{1'b1, w, v, ln, a};
        #1;
        while (arb_in_n_i !== perm && n < 20) begin
            @(posedge ref_clk_i);
            #1 n++;
        end
        if (exp && n == 20) begin
            n_mismatch++;
            conclude();
        end
        @(posedge ref_clk_i);
        req_i.valid <= 1'b0;
        #1 cmp("req_ack_o", exp, req_ack_o);
        cmp("select_n", sel, pins_o.select_n);
        if (exp) begin
            cmp("read_n", w, pins_o.read_n);
            cmp("lane_two", !(ln[1] && (dyn || w)), pins_o.lane_two_strobe_n);
            cmp("lane_low", !(ln[0] && (dyn || w)), pins_o.lane_low_strobe_n);
            cmp("ext_addr", a[26:0], pins_o.addr);
            cmp("vector", v, pins_o.vector_fetch_indicator);
        end
        if (exp && !w) begin
            cmp("rd_data", {16'h0, a[15:0]}, {16'h0, rd_data});
        end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (20) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].a, rows[i].wide, rows[i].d);
            end else begin
                rd(rows[i].a, rows[i].wide, rows[i].d);
            end
        end
        // Every memory kind, both lanes, both directions in space three
        for (int k = 0; k < 4; k++) begin
            kind = k[1:0];
            wr(32'hFFFFFFE0, 1'b1, {16'hA55A, 16'h03F0 | k[15:0]});
            for (int j = 0; j < 4; j++) begin
                acc(32'h26000010, j[1], j[0] ? 2'h1 : 2'h2, 1'b0, 1'b1, 1'b1);
            end
        end
        // Each space, cached and cache-through alternately; then a non-external address
        for (int s = 0; s < 4; s++) begin
            acc({2'h0, s[0], 2'h0, s[1:0], 25'h10}, 1'b1, 2'h3, s[0], 1'b1, 1'b1);
        end
        acc(32'h40000000, 1'b0, 2'h3, 1'b0, 1'b1, 1'b0);
        // Total master: release request hands the bus over and blocks accesses
        @(posedge ref_clk_i);
        rel <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1 cmp("arb_out_n", 1'b0, pins_o.arb_out_n);
        cmp("drive_oe_n", 1'b1, pins_o.drive_oe_n);
        cmp("cke", 1'b1, pins_o.sdram_clock_enable);
        acc(32'h00000020, 1'b0, 2'h3, 1'b0, 1'b1, 1'b0);
        @(posedge ref_clk_i);
        rel <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1 cmp("arb_out_n", 1'b1, pins_o.arb_out_n);
        // Slave: strap shows in the register, access waits for permission
        @(posedge ref_clk_i);
        slave_mode_i <= 1'b1;
        total <= 1'b0;
        rd(32'hFFFFFFE2, 1'b0, 32'h83F3);
        acc(32'h02000040, 1'b0, 2'h3, 1'b0, 1'b0, 1'b1);
        @(posedge ref_clk_i);
        slave_mode_i <= 1'b0;
        // Partial share: space zero goes freely, space two waits for permission
        wr(32'hFFFFFFE0, 1'b1, 32'hA55A07F3);
        acc(32'h00000050, 1'b0, 2'h3, 1'b0, 1'b1, 1'b1);
        acc(32'h04000060, 1'b0, 2'h3, 1'b0, 1'b0, 1'b1);
        @(posedge ref_clk_i);
        total <= 1'b1;
        // Self-refresh drops the clock enable and restores it
        wr(32'hFFFFFFF0, 1'b1, 32'hA55A0001);
        rd(32'hFFFFFFF0, 1'b1, 32'h1);
        cmp("cke", 1'b0, pins_o.sdram_clock_enable);
        wr(32'hFFFFFFF0, 1'b1, 32'hA55A0000);
        rd(32'hFFFFFFF2, 1'b0, 32'h0);
        cmp("cke", 1'b1, pins_o.sdram_clock_enable);
        // Second reset in mid-run restores pin levels and register values
        @(posedge ref_clk_i);
        rstn_i <= 1'b0;
        #1 cmp("select_n", 4'hF, pins_o.select_n);
        cmp("reg_rdata_o", 32'h0, reg_rdata_o);
        repeat (2) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        kind = 2'h0;
        rd(32'hFFFFFFE6, 1'b0, 32'h00FC);
        conclude();
    end
endmodule
